/* rtl/gsdp_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module gsdp_regs
    import gsdp_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          nrst_in,
    input  wire logic [7:0]    reg_addr_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    input  wire logic [7:0]    reg_wdata_in,
    output logic [7:0]         reg_rdata_out,
    input  wire gsdp_irq_cfg_t irq_cfg_in,
    input  wire gsdp_sample_t  sample_in,
    input  wire logic          sample_valid_in,
    input  wire logic          pll_locked_in,
    output logic               irq_out,
    output logic               sleep_out,
    output logic [2:0]         standby_out,
    output logic [2:0]         clock_select_out,
    output logic               soft_reset_out
);

    // Address 1A holds the status flags and is read only.
    // Addresses 1B to 22 hold the four result words, high byte first.
    // Address 3E holds the power and clock control byte, read and write.
    // Every other address reads as zero, and every write there is dropped.
    // Read data stands from the cycle after the strobe until the next read.
    // A power write drives sleep, standby and clock select one cycle later.
    // A write with bit 7 set raises soft_reset_out for one cycle, and the
    // edge after that pulse returns flags, results, read data and a pulsed pin
    // to their defaults, while a latched pin follows the flags one edge later;
    // the power byte itself is cleared at once.
    // A burst keeps high and low bytes of one word together only while no
    // new sample lands between its reads, so the host should read on the
    // data interrupt and finish the burst well before the next sample.
    // Reserved clock codes are stored and passed on to the clock unit.

    // Picks one byte of a 16-bit result word.
    function automatic logic [7:0] pick_byte(
        input logic [15:0] word,
        input logic        high
    );
        pick_byte = high ? word[15:8] : word[7:0];
    endfunction : pick_byte

    // Address decode for reads; unmapped addresses answer zero.
    function automatic logic [7:0] read_mux(
        input logic [7:0]   addr,
        input logic [7:0]   flags_v,
        input logic [7:0]   power_v,
        input gsdp_sample_t res_v
    );
        if (addr == ADDR_FLAGS) begin
            read_mux = flags_v;
        end else if (addr == ADDR_TEMP_HI) begin
            read_mux = pick_byte(res_v.temp, 1'b1);
        end else if (addr == ADDR_TEMP_LO) begin
            read_mux = pick_byte(res_v.temp, 1'b0);
        end else if (addr == ADDR_X_HI) begin
            read_mux = pick_byte(res_v.x, 1'b1);
        end else if (addr == ADDR_X_LO) begin
            read_mux = pick_byte(res_v.x, 1'b0);
        end else if (addr == ADDR_Y_HI) begin
            read_mux = pick_byte(res_v.y, 1'b1);
        end else if (addr == ADDR_Y_LO) begin
            read_mux = pick_byte(res_v.y, 1'b0);
        end else if (addr == ADDR_Z_HI) begin
            read_mux = pick_byte(res_v.z, 1'b1);
        end else if (addr == ADDR_Z_LO) begin
            read_mux = pick_byte(res_v.z, 1'b0);
        end else if (addr == ADDR_POWER) begin
            read_mux = power_v;
        end else begin
            read_mux = RDATA_RESET;
        end
    endfunction : read_mux

    // Next value of one status bit. The set wins over a clear in the same
    // cycle, so an event that lands during a status read is never lost.
    function automatic logic flag_update(
        input logic old_v,
        input logic set_v,
        input logic clr_v
    );
        if (set_v) begin
            flag_update = 1'b1;
        end else if (clr_v) begin
            flag_update = 1'b0;
        end else begin
            flag_update = old_v;
        end
    endfunction : flag_update

    // True for every clock code except the internal oscillator. Reserved codes
    // are treated as loop sources, so a switch to them waits for a lock.
    function automatic logic needs_lock(
        input logic [2:0] code
    );
        if (code == CLK_PLL_X || code == CLK_PLL_Y || code == CLK_PLL_Z) begin
            needs_lock = 1'b1;
        end else if (code == CLK_EXT_32K || code == CLK_EXT_19M) begin
            needs_lock = 1'b1;
        end else if (code == CLK_INTERNAL) begin
            needs_lock = 1'b0;
        end else begin
            needs_lock = 1'b1;
        end
    endfunction : needs_lock

    logic [7:0]   flags;
    logic [7:0]   next_flags;
    logic [7:0]   power;
    logic [7:0]   next_power;
    logic [7:0]   next_rdata;
    logic         pll_wait;
    logic         next_pll_wait;
    logic         next_soft_reset;
    logic         reset_write;
    logic         power_write;
    logic         clear_read;
    logic         status_read;
    logic         data_event;
    logic         pll_event;
    logic         data_set;
    logic         pll_set;
    logic         irq_event;
    logic [2:0]   new_clock;
    gsdp_sample_t results;

    // Write decode; the reset bit takes priority over storing the byte.
    // Storing the other fields of that byte would be pointless, since the
    // device reset returns every field to its default.
    assign power_write = reg_wr_in && (reg_addr_in == ADDR_POWER);
    assign reset_write = power_write && reg_wdata_in[PWR_RESET_BIT];
    assign new_clock   = reg_wdata_in[PWR_CLK_LSB +: 3];

    // A status read is the only read that clears in the status-only method.
    assign status_read = reg_rd_in && (reg_addr_in == ADDR_FLAGS);

    // Sleep stops new results but the register file keeps answering.
    // Lock tracking and the read path keep running, so the host can still
    // read the held results and clear flags while the sensor rests.
    assign data_event = sample_valid_in && !sleep_out;

    // A reference switch arms the wait; the internal oscillator needs no lock.
    // Arming only on a real change of code avoids a spurious lock event
    // when the host rewrites the power byte with the same clock source.
    assign pll_event = pll_wait
        && (pll_locked_in || !needs_lock(clock_select_out));

    // Each source passes only through its own enable.
    assign data_set = data_event && irq_cfg_in.data_ready_irq_enable;
    assign pll_set  = pll_event && irq_cfg_in.pll_locked_irq_enable;
    assign irq_event = data_set || pll_set;

    // Clear condition follows the clear-method bit.
    // The read strobe counts whatever the address, so in the any-read
    // method a read of an unmapped address clears the flags as well.
    always_comb begin
        if (irq_cfg_in.clear_on_any_read) begin
            clear_read = reg_rd_in;
        end else begin
            clear_read = status_read;
        end
    end

    // Flag update. Only bits 2 and 0 exist; every other bit reads zero.
    // Pin polarity and latch mode never enter this path, so the flags mean
    // the same thing whatever the pin is set up to do.
    // A device reset overrides everything, including a set in that cycle.
    always_comb begin
        next_flags = FLAGS_RESET;
        next_flags[FLAG_DATA_BIT] =
            flag_update(flags[FLAG_DATA_BIT], data_set, clear_read);
        next_flags[FLAG_PLL_BIT] =
            flag_update(flags[FLAG_PLL_BIT], pll_set, clear_read);
        if (soft_reset_out) begin
            next_flags = FLAGS_RESET;
        end
    end

    // Power register and PLL lock tracking. The reset bit itself is never
    // stored, so the register reads back its default after a device reset.
    // A lock event and a clock write in one cycle leave the wait armed,
    // because that lock belonged to the old source.
    always_comb begin
        next_power      = power;
        next_pll_wait   = pll_wait;
        next_soft_reset = 1'b0;
        if (pll_event) begin
            next_pll_wait = 1'b0;
        end
        if (reset_write) begin
            next_power      = POWER_RESET;
            next_pll_wait   = 1'b0;
            next_soft_reset = 1'b1;
        end else if (power_write) begin
            next_power = reg_wdata_in;
            if (new_clock != clock_select_out) begin
                next_pll_wait = 1'b1;
            end
        end
    end

    // Read data is captured on the read strobe from the pre-clear values.
    // Capturing before the clear is what lets a status read report the
    // flags that the same read is about to clear.
    // Writes to the status and result addresses fall through unused.
    always_comb begin
        next_rdata = reg_rdata_out;
        if (reg_rd_in) begin
            next_rdata = read_mux(reg_addr_in, flags, power, results);
        end
        if (soft_reset_out) begin
            next_rdata = RDATA_RESET;
        end
    end

    // Status flag register. Only the pin reset is handled here; the device
    // reset arrives through next_flags like any other update.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // Power byte, lock tracking and the one-cycle device reset pulse.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            power          <= POWER_RESET;
            pll_wait       <= 1'b0;
            soft_reset_out <= 1'b0;
        end else begin
            power          <= next_power;
            pll_wait       <= next_pll_wait;
            soft_reset_out <= next_soft_reset;
        end
    end

    // Read data register; it holds its byte between reads.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= RDATA_RESET;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

    // Power controls drive the analogue side straight from the register.
    assign sleep_out = power[PWR_SLEEP_BIT];

    // Standby order is X, Y, Z from high bit to low bit.
    // A channel in standby keeps its last result in the result store.
    assign standby_out = {power[PWR_X_STBY_BIT],
                          power[PWR_Y_STBY_BIT],
                          power[PWR_Z_STBY_BIT]};

    // Reserved codes are passed through; the clock unit decides what they do.
    assign clock_select_out = power[PWR_CLK_LSB +: 3];

    // Result storage, cleared with the flags and read data on the edge after the device reset pulse.
    gsdp_results u_results (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .clear_in    (soft_reset_out),
        .capture_in  (data_event),
        .standby_in  (standby_out),
        .sample_in   (sample_in),
        .results_out (results)
    );

    // Interrupt pin: pulse or latch, with polarity applied last.
    // The pin sees every enabled event even in latch mode, so a pulse that
    // is still running carries on if the host switches to pulse mode.
    gsdp_irq_pin u_irq_pin (
        .clk_in     (clk_in),
        .nrst_in    (nrst_in),
        .clear_in   (soft_reset_out),
        .cfg_in     (irq_cfg_in),
        .pending_in (|flags),
        .event_in   (irq_event),
        .irq_out    (irq_out)
    );

endmodule : gsdp_regs
`default_nettype wire

/* rtl/gsdp_pkg.sv */
`default_nettype none
package gsdp_pkg;

    // Register addresses as seen behind the serial interface.
    localparam logic [7:0] ADDR_FLAGS   = 8'h1A;
    localparam logic [7:0] ADDR_TEMP_HI = 8'h1B;
    localparam logic [7:0] ADDR_TEMP_LO = 8'h1C;
    localparam logic [7:0] ADDR_X_HI    = 8'h1D;
    localparam logic [7:0] ADDR_X_LO    = 8'h1E;
    localparam logic [7:0] ADDR_Y_HI    = 8'h1F;
    localparam logic [7:0] ADDR_Y_LO    = 8'h20;
    localparam logic [7:0] ADDR_Z_HI    = 8'h21;
    localparam logic [7:0] ADDR_Z_LO    = 8'h22;
    localparam logic [7:0] ADDR_POWER   = 8'h3E;

    // Field positions in the status and power registers.
    localparam int FLAG_DATA_BIT  = 0;
    localparam int FLAG_PLL_BIT   = 2;
    localparam int PWR_RESET_BIT  = 7;
    localparam int PWR_SLEEP_BIT  = 6;
    localparam int PWR_X_STBY_BIT = 5;
    localparam int PWR_Y_STBY_BIT = 4;
    localparam int PWR_Z_STBY_BIT = 3;
    localparam int PWR_CLK_LSB    = 0;

    // Reset values.
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  POWER_RESET  = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0]  RDATA_RESET  = 8'h00;

    // Clock source codes; 6 and 7 are reserved.
    localparam logic [2:0] CLK_INTERNAL = 3'h0;
    localparam logic [2:0] CLK_PLL_X    = 3'h1;
    localparam logic [2:0] CLK_PLL_Y    = 3'h2;
    localparam logic [2:0] CLK_PLL_Z    = 3'h3;
    localparam logic [2:0] CLK_EXT_32K  = 3'h4;
    localparam logic [2:0] CLK_EXT_19M  = 3'h5;

    // Interrupt pulse width, derived from the 25 MHz clock.
    localparam int CLK_PERIOD_NS    = 40;
    localparam int IRQ_PULSE_NS     = 50000;
    localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [10:0] PULSE_LOAD = 11'(IRQ_PULSE_CYCLES);
    localparam logic [10:0] PULSE_ZERO = 11'h000;

    // One complete set of sensor results.
    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } gsdp_sample_t;

    // Interrupt configuration bits that live outside this block.
    typedef struct packed {
        logic irq_active_low;
        logic latch_mode;
        logic clear_on_any_read;
        logic pll_locked_irq_enable;
        logic data_ready_irq_enable;
    } gsdp_irq_cfg_t;

endpackage : gsdp_pkg
`default_nettype wire

/* rtl/gsdp_results.sv */
`timescale 1ns/100ps
`default_nettype none
module gsdp_results
    import gsdp_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic         clear_in,
    input  wire logic         capture_in,
    input  wire logic [2:0]   standby_in,
    input  wire gsdp_sample_t sample_in,
    output gsdp_sample_t      results_out
);

    gsdp_sample_t next_results;

    // All four words load in the same edge; a burst that spans a new sample still mixes them.
    // A channel in standby keeps its last value.
    always_comb begin
        next_results = results_out;
        if (clear_in) begin
            next_results = '{RESULT_RESET, RESULT_RESET, RESULT_RESET, RESULT_RESET};
        end else if (capture_in) begin
            next_results.temp = sample_in.temp;
            if (!standby_in[2]) next_results.x = sample_in.x;
            if (!standby_in[1]) next_results.y = sample_in.y;
            if (!standby_in[0]) next_results.z = sample_in.z;
        end
    end

    // Result storage.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            results_out <= '{RESULT_RESET, RESULT_RESET, RESULT_RESET, RESULT_RESET};
        end else begin
            results_out <= next_results;
        end
    end

endmodule : gsdp_results
`default_nettype wire

/* rtl/gsdp_irq_pin.sv */
`timescale 1ns/100ps
`default_nettype none
module gsdp_irq_pin
    import gsdp_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          nrst_in,
    input  wire logic          clear_in,
    input  wire gsdp_irq_cfg_t cfg_in,
    input  wire logic          pending_in,
    input  wire logic          event_in,
    output logic               irq_out
);

    typedef enum logic [0:0] {PULSE_IDLE, PULSE_ON} gsdp_pulse_t;

    gsdp_pulse_t state;
    gsdp_pulse_t next_state;
    logic [10:0] count;
    logic [10:0] next_count;
    logic        next_irq;
    logic        active;

    // Each new event restarts a fixed-width pulse; latch mode follows the flags.
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            PULSE_IDLE: begin
                if (event_in && !clear_in) begin
                    next_state = PULSE_ON;
                    next_count = PULSE_LOAD - 11'h001;
                end
            end
            PULSE_ON: begin
                if (clear_in) begin
                    next_state = PULSE_IDLE;
                end else if (event_in) begin
                    next_count = PULSE_LOAD - 11'h001;
                end else if (count == PULSE_ZERO) begin
                    next_state = PULSE_IDLE;
                end else begin
                    next_count = count - 11'h001;
                end
            end
            default: next_state = PULSE_IDLE;
        endcase
        active   = cfg_in.latch_mode ? pending_in : (next_state == PULSE_ON);
        next_irq = active ^ cfg_in.irq_active_low;
    end

    // Pulse state and the registered pin level.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state   <= PULSE_IDLE;
            count   <= PULSE_ZERO;
            irq_out <= 1'b0;
        end else begin
            state   <= next_state;
            count   <= next_count;
            irq_out <= next_irq;
        end
    end

endmodule : gsdp_irq_pin
`default_nettype wire

/* testbench/gsdp_host.sv */
`timescale 1ns/100ps
`default_nettype none
module gsdp_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic [7:0]      addr_out,
    output logic            wr_out,
    output logic            rd_out,
    output logic [7:0]      wdata_out
);
    // Idle bus: no strobe, and no real register sitting on the address.
    initial begin
        addr_out = 8'hC3;
        wdata_out = 8'h3C;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // One write; released data is inverted so nothing leans on a stale byte.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask : wr

    // One read at any moment; the byte is taken one cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        d = rdata_in;
        addr_out = ~a;
    endtask : rd
endmodule : gsdp_host
`default_nettype wire

/* testbench/gsdp_regs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module gsdp_regs_monitor
    import gsdp_pkg::*;
(
    input wire logic          clk_in,
    input wire logic          nrst_in,
    input wire logic [7:0]    reg_addr_in,
    input wire logic          reg_wr_in,
    input wire logic          reg_rd_in,
    input wire logic [7:0]    reg_wdata_in,
    input wire logic [7:0]    reg_rdata_out,
    input wire gsdp_irq_cfg_t irq_cfg_in,
    input wire logic          sample_valid_in,
    input wire logic          irq_out,
    input wire logic          sleep_out,
    input wire logic [2:0]    standby_out,
    input wire logic [2:0]    clock_select_out,
    input wire logic          soft_reset_out
);
    // Power register as the pins show it, and a write aimed at it.
    logic [6:0]  pv;
    logic        pw;
    logic [11:0] hi_cnt;
    logic [11:0] next_hi_cnt;
    assign pv = {sleep_out, standby_out, clock_select_out};
    assign pw = reg_wr_in && reg_addr_in == ADDR_POWER;

    // Length of the current high stretch; wide enough for any single pulse.
    always_comb next_hi_cnt = irq_out ? hi_cnt + 12'h001 : 12'h000;
    always_ff @(posedge clk_in or negedge nrst_in)
        if (!nrst_in) hi_cnt <= 12'h000;
        else hi_cnt <= next_hi_cnt;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    chk_flags_bits: assert property (
        reg_rd_in && reg_addr_in == ADDR_FLAGS |=> (reg_rdata_out & 8'hFA) == 8'h00)
        else $error("status shows an undefined bit");
    chk_power_read: assert property (
        reg_rd_in && reg_addr_in == ADDR_POWER |=> reg_rdata_out == {1'b0, $past(pv)})
        else $error("power read-back wrong");
    chk_power_write: assert property (
        pw && !reg_wdata_in[7] |=> pv == $past(reg_wdata_in[6:0]))
        else $error("power pins do not follow write");
    chk_soft_pulse: assert property (
        pw && reg_wdata_in[7] |=> soft_reset_out && pv == 7'h00 ##1 !soft_reset_out)
        else $error("soft reset pulse wrong");
    chk_soft_clear: assert property (
        soft_reset_out |=> reg_rdata_out == 8'h00)
        else $error("read data kept over soft reset");
    chk_ro_write: assert property (
        reg_wr_in && !pw |=> $stable(pv) && $stable(reg_rdata_out))
        else $error("write to read-only place took effect");
    chk_irq_data: assert property (
        sample_valid_in && !sleep_out && irq_cfg_in.data_ready_irq_enable
        && !irq_cfg_in.irq_active_low |-> ##2 irq_out)
        else $error("no interrupt after new sample");
    chk_pulse_len: assert property (
        $fell(irq_out) && !irq_cfg_in.latch_mode && !irq_cfg_in.irq_active_low
        |-> hi_cnt >= 12'(IRQ_PULSE_CYCLES))
        else $error("interrupt pulse too short");
endmodule : gsdp_regs_monitor

bind gsdp_regs gsdp_regs_monitor mon (.clk_in, .nrst_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .irq_cfg_in, .sample_valid_in, .irq_out,
    .sleep_out, .standby_out, .clock_select_out, .soft_reset_out);
`default_nettype wire

/* testbench/gsdp_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module gsdp_regs_test
    import gsdp_pkg::*;
;
    logic          clk_in  = 1'b0;
    logic          nrst_in = 1'b0;
    logic          valid   = 1'b0;
    logic          locked  = 1'b0;
    logic          wr, rd, irq, sleep, srst;
    logic [7:0]    addr, wdata, rdata, v;
    logic [2:0]    stby, csel;
    gsdp_irq_cfg_t cfg = 5'h00;
    gsdp_sample_t  smp = 64'h0;
    logic [63:0]   res;
    int            err_count = 0;
    int            n_tests   = 0;
    int            k;
    // Plain accesses as {address, write data, expected read-back}.
    logic [23:0]   rows [6] = '{24'h3E7F7F, 24'h3E2D2D, 24'h1AFF00, 24'h1B5500,
                                24'h40AA00, 24'h3E0000};

    // 25 MHz clock.
    always #20 clk_in = ~clk_in;

    gsdp_regs uut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .irq_cfg_in(cfg),
        .sample_in(smp), .sample_valid_in(valid), .pll_locked_in(locked), .irq_out(irq),
        .sleep_out(sleep), .standby_out(stby), .clock_select_out(csel),
        .soft_reset_out(srst));
    gsdp_host h (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata));

    // Inputs always move 1 ns after an edge, so no race with the design.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic fire(input gsdp_sample_t s);
        smp = s;
        valid = 1'b1;
        tick(1);
        valid = 1'b0;
    endtask : fire

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("mismatches %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Table first, then the awkward cases by hand.
    initial begin
        tick(4);
        nrst_in = 1'b1;
        chk({rdata, sleep, stby, csel, srst}, 16'h0000);
        for (k = 0; k < 6; k++) begin
            h.wr(rows[k][23:16], rows[k][15:8]);
            h.rd(rows[k][23:16], v);
            chk(v, rows[k][7:0]);
        end
        for (k = 0; k < 8; k++) begin
            h.wr(ADDR_POWER, 8'(k));
            h.rd(ADDR_POWER, v);
            chk(v, 8'(k));
        end
        // Run from the X-axis loop and park the unused Z channel.
        h.wr(ADDR_POWER, 8'h09);
        cfg = 5'h09; // Latched pin, data source on.
        fire(64'h8001_1234_ABCD_7F00);
        tick(1);
        chk(irq, 1'b1);
        res = 64'h8001_1234_ABCD_0000;
        for (k = 0; k < 8; k++) begin
            h.rd(ADDR_TEMP_HI + 8'(k), v);
            chk(v, res[63 - 8 * k -: 8]);
        end
        chk(irq, 1'b1);
        h.rd(ADDR_FLAGS, v);
        chk(v, 8'h01);
        tick(1);
        chk(irq, 1'b0);
        cfg = 5'h0D; // Any read now clears.
        fire(64'h0102_0304_0506_0708);
        h.rd(ADDR_Y_LO, v);
        chk(v, 8'h06);
        h.rd(ADDR_FLAGS, v);
        chk(v, 8'h00);
        cfg = 5'h08; // Data source off.
        fire(64'hFFFF_0000_0000_0000);
        h.rd(ADDR_TEMP_LO, v);
        chk(v, 8'hFF);
        h.rd(ADDR_FLAGS, v);
        chk({v, 7'h00, irq}, 16'h0000);
        h.wr(ADDR_POWER, 8'h49);
        fire(64'h1111_1111_1111_1111);
        h.rd(ADDR_TEMP_HI, v);
        chk(v, 8'hFF);
        h.wr(ADDR_POWER, 8'h08);
        h.rd(ADDR_FLAGS, v);
        cfg = 5'h0A; // Lock source on, loop not yet locked.
        h.wr(ADDR_POWER, 8'h01);
        tick(3);
        h.rd(ADDR_FLAGS, v);
        chk(v, 8'h00);
        locked = 1'b1;
        tick(3);
        h.rd(ADDR_FLAGS, v);
        chk(v, 8'h04);
        tick(2);
        cfg = 5'h01; // Pulse mode, active high.
        fire(64'h0);
        k = 0;
        while (irq === 1'b1 && k < 2000) begin
            k++;
            tick(1);
        end
        chk(16'(k), 16'(IRQ_PULSE_CYCLES));
        h.rd(ADDR_FLAGS, v);
        chk(v, 8'h01);
        cfg = 5'h11; // Same, but the pin is active low.
        tick(2);
        chk(irq, 1'b1);
        fire(64'h7777_7777_7777_7777);
        tick(1);
        chk(irq, 1'b0);
        h.rd(ADDR_FLAGS, v);
        chk(v, 8'h01);
        tick(1300);
        cfg = 5'h08;
        h.wr(ADDR_POWER, 8'h80);
        chk(srst, 1'b1);
        h.rd(ADDR_TEMP_HI, v);
        chk(v, 8'h00);
        h.wr(ADDR_POWER, 8'h2D);
        nrst_in = 1'b0;
        tick(1);
        nrst_in = 1'b1;
        h.rd(ADDR_POWER, v);
        chk(v, 8'h00);
        complete_run();
    end

    // The run needs about 2700 cycles; over seven times that means a hang.
    initial begin
        #(40 * 20000);
        err_count++;
        complete_run();
    end
endmodule : gsdp_regs_test
`default_nettype wire
